// file: hw/fbl_loader.sv
/*
 * Boot image loader: strap recovery erase, validation and length header,
 * flash-to-RAM copy, debug port gating and exit pad setup.
 * Assumes the flash serial clock arrives on LINK_CLK and runs while the
 * loader has an operation pending; RAM answers with a stall input.
 */
`timescale 1ns/1ps
`default_nettype none

module fbl_loader #(
	parameter int ERASE_CYCLES = fbl_pkg::SECTOR_ERASE_CYC,
	parameter logic [31:0] LOADER_VERSION = 32'h0001_0000 // Arbitrary value
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic LINK_CLK,
	input wire logic FLASH_MISO,
	output logic FLASH_CS_N,
	output logic FLASH_MOSI,
	output logic FLASH_REG_EN,
	input wire logic WAKE,
	input wire logic STRAP_HI,
	input wire logic STRAP_LO,
	input wire fbl_pkg::fbl_src_t SEC_SRC,
	output fbl_pkg::fbl_pad_cfg_t PAD_CFG,
	output logic [31:0] RAM_ADDR,
	output logic [7:0] RAM_WDATA,
	output logic RAM_WE,
	output logic [3:0] RAM_BANK_SEL,
	input wire logic RAM_STALL,
	input wire logic SLEEP,
	input wire logic [2:0] SLEEP_BANK_OFF,
	output logic [3:0] RAM_BANK_PWR,
	output logic [3:0] RAM_RETAIN,
	input wire logic [31:0] ROM_ADDR,
	output logic [31:0] ROM_RDATA,
	output logic DEBUG_EN,
	output logic BOOT_DONE,
	output logic [31:0] BOOT_PC,
	output logic NO_IMAGE,
	output logic ERASE_DONE
);

	function automatic logic [3:0] bank_of(input logic [16:0] a);
		if (a >= fbl_pkg::BANK3_OFS)
			bank_of = 4'h8;
		else if (a >= fbl_pkg::BANK2_OFS)
			bank_of = 4'h4;
		else if (a >= fbl_pkg::BANK1_OFS)
			bank_of = 4'h2;
		else
			bank_of = 4'h1;
	endfunction : bank_of

	fbl_pkg::fbl_state_t state_reg;
	fbl_pkg::fbl_link_req_t req_reg;
	logic req_tgl_reg;
	logic busy_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;
	logic link_done;
	logic hi_s1_reg, hi_s2_reg, lo_s1_reg, lo_s2_reg;
	logic [31:0] wait_reg;
	logic [4:0] sector_reg;
	logic [2:0] byte_reg;
	logic [31:0] hdr_reg;
	logic [31:0] len_reg;
	logic [31:0] len_next;
	logic [31:0] hdr_next;
	logic [16:0] addr_reg;
	logic image_ok_reg;
	logic [1:0] wr_cnt_reg;

	// Link domain
	logic l_req_s1_reg, l_req_s2_reg, l_seen_reg, l_ack_reg, l_busy_reg;
	logic [5:0] l_cnt_reg;
	logic [31:0] l_out_reg;
	logic [31:0] l_in_reg;
	logic l_rel_reg;
	logic l_cs_n_reg;

	always_ff @(posedge LINK_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			l_req_s1_reg <= 1'b0;
			l_req_s2_reg <= 1'b0;
		end
		else
		begin
			l_req_s1_reg <= req_tgl_reg;
			l_req_s2_reg <= l_req_s1_reg;
		end
	end

	// Request word is held still by the core until the ack returns
	always_ff @(posedge LINK_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			l_seen_reg <= 1'b0;
			l_ack_reg <= 1'b0;
			l_busy_reg <= 1'b0;
			l_cnt_reg <= 6'h0;
			l_out_reg <= 32'h0;
			l_in_reg <= 32'h0;
			l_rel_reg <= 1'b0;
			l_cs_n_reg <= 1'b1;
		end
		else if (!l_busy_reg && l_req_s2_reg != l_seen_reg)
		begin
			l_seen_reg <= l_req_s2_reg;
			l_busy_reg <= 1'b1;
			l_cnt_reg <= req_reg.nbits;
			l_out_reg <= req_reg.data;
			l_rel_reg <= req_reg.release_cs;
			l_cs_n_reg <= 1'b0;
		end
		else if (l_busy_reg)
		begin
			l_out_reg <= {l_out_reg[30:0], 1'b0};
			l_in_reg <= {l_in_reg[30:0], FLASH_MISO};
			l_cnt_reg <= l_cnt_reg - 6'h1;
			if (l_cnt_reg == 6'h1)
			begin
				l_busy_reg <= 1'b0;
				l_ack_reg <= ~l_ack_reg;
				l_cs_n_reg <= l_rel_reg;
			end
		end
	end

	assign FLASH_CS_N = l_cs_n_reg;
	assign FLASH_MOSI = l_busy_reg & l_out_reg[31];

	// Core domain
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
			hi_s1_reg <= 1'b1;
			hi_s2_reg <= 1'b1;
			lo_s1_reg <= 1'b0;
			lo_s2_reg <= 1'b0;
		end
		else
		begin
			ack_s1_reg <= l_ack_reg;
			ack_s2_reg <= ack_s1_reg;
			hi_s1_reg <= STRAP_HI;
			hi_s2_reg <= hi_s1_reg;
			lo_s1_reg <= STRAP_LO;
			lo_s2_reg <= lo_s1_reg;
		end
	end

	assign link_done = busy_reg && (ack_s2_reg == req_tgl_reg);
	assign hdr_next = {hdr_reg[23:0], l_in_reg[7:0]};
	assign len_next = {l_in_reg[7:0], len_reg[31:8]};

	function automatic fbl_pkg::fbl_link_req_t op_of(
		input fbl_pkg::fbl_state_t st, input logic [4:0] sec);
		op_of = '{release_cs: 1'b0, nbits: 6'h08, data: 32'h0};
		case (st)
			fbl_pkg::ST_ERASE_WREN:
				op_of = '{1'b1, 6'h08, {fbl_pkg::CMD_WREN, 24'h0}};
			fbl_pkg::ST_ERASE_CMD:
				op_of = '{1'b1, 6'h20, {fbl_pkg::CMD_SECTOR_ERASE, 7'h0,
					sec, 12'h0}};
			fbl_pkg::ST_OPEN:
				op_of = '{1'b0, 6'h20, {fbl_pkg::CMD_READ, 24'h0}};
			fbl_pkg::ST_CLOSE:
				op_of = '{1'b1, 6'h08, 32'h0};
			default:
				op_of = '{release_cs: 1'b0, nbits: 6'h08, data: 32'h0};
		endcase
	endfunction : op_of

	// Issue one link operation per state visit, and one per header byte while in ST_HDR
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			req_reg <= '0;
			req_tgl_reg <= 1'b0;
			busy_reg <= 1'b0;
		end
		else if (link_done)
			busy_reg <= 1'b0;
		else if (!busy_reg && (state_reg == fbl_pkg::ST_ERASE_WREN ||
			state_reg == fbl_pkg::ST_ERASE_CMD ||
			state_reg == fbl_pkg::ST_OPEN || state_reg == fbl_pkg::ST_HDR ||
			state_reg == fbl_pkg::ST_COPY || state_reg == fbl_pkg::ST_CLOSE))
		begin
			req_reg <= op_of(state_reg, sector_reg);
			req_tgl_reg <= ~req_tgl_reg;
			busy_reg <= 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			state_reg <= fbl_pkg::ST_CHECK;
			wait_reg <= 32'h0;
			sector_reg <= 5'h0;
			byte_reg <= 3'h0;
			hdr_reg <= 32'h0;
			len_reg <= 32'h0;
			addr_reg <= 17'h0;
			image_ok_reg <= 1'b0;
			wr_cnt_reg <= 2'h0;
			FLASH_REG_EN <= 1'b0;
			DEBUG_EN <= 1'b0;
			RAM_WE <= 1'b0;
			RAM_WDATA <= 8'h0;
		end
		else
		begin
			case (state_reg)
				fbl_pkg::ST_CHECK:
					if (WAKE)
						state_reg <= fbl_pkg::ST_DONE;
					else
					begin
						FLASH_REG_EN <= 1'b1;
						wait_reg <= 32'h0;
						state_reg <= fbl_pkg::ST_STRAP;
					end
				fbl_pkg::ST_STRAP:
					if (wait_reg < 32'(fbl_pkg::STRAP_SETTLE_CYC - 1))
						wait_reg <= wait_reg + 32'h1;
					else if (!hi_s2_reg && lo_s2_reg)
						state_reg <= fbl_pkg::ST_ERASE_WREN;
					else
						state_reg <= fbl_pkg::ST_OPEN;
				fbl_pkg::ST_ERASE_WREN:
					if (link_done)
						state_reg <= fbl_pkg::ST_ERASE_CMD;
				fbl_pkg::ST_ERASE_CMD:
					if (link_done)
					begin
						wait_reg <= 32'h0;
						state_reg <= fbl_pkg::ST_ERASE_WAIT;
					end
				fbl_pkg::ST_ERASE_WAIT:
					if (wait_reg < 32'(ERASE_CYCLES - 1))
						wait_reg <= wait_reg + 32'h1;
					// Top sector left alone for factory data
					else if ({1'b0, sector_reg} ==
						fbl_pkg::FLASH_SECTORS - 6'h2)
						state_reg <= fbl_pkg::ST_ERASE_HOLD;
					else
					begin
						sector_reg <= sector_reg + 5'h1;
						state_reg <= fbl_pkg::ST_ERASE_WREN;
					end
				fbl_pkg::ST_ERASE_HOLD:
					state_reg <= fbl_pkg::ST_ERASE_HOLD;
				fbl_pkg::ST_OPEN:
					if (link_done)
					begin
						byte_reg <= 3'h0;
						state_reg <= fbl_pkg::ST_HDR;
					end
				fbl_pkg::ST_HDR:
					if (link_done)
					begin
						byte_reg <= byte_reg + 3'h1;
						if (byte_reg < 3'h4)
							hdr_reg <= hdr_next;
						else
							len_reg <= len_next;
						if (byte_reg == 3'h3)
						begin
							if (hdr_next != fbl_pkg::WORD_SECU)
								DEBUG_EN <= 1'b1;
							if (hdr_next == fbl_pkg::WORD_SECU ||
								hdr_next == fbl_pkg::WORD_OKOK)
								image_ok_reg <= 1'b1;
							else
								state_reg <= fbl_pkg::ST_CLOSE;
						end
						if (byte_reg == 3'h7)
						begin
							// Corrupt count must not run past bank three
							if (len_next > fbl_pkg::RAM_BYTES)
								len_reg <= fbl_pkg::RAM_BYTES;
							state_reg <= (len_next == 32'h0) ?
								fbl_pkg::ST_CLOSE : fbl_pkg::ST_COPY;
						end
					end
				fbl_pkg::ST_COPY:
					if (link_done)
					begin
						RAM_WDATA <= l_in_reg[7:0];
						RAM_WE <= 1'b1;
						wr_cnt_reg <= 2'h0;
						state_reg <= fbl_pkg::ST_WRITE;
					end
				fbl_pkg::ST_WRITE:
					if (wr_cnt_reg < 2'(fbl_pkg::RAM_ACCESS_CYC - 1))
						wr_cnt_reg <= wr_cnt_reg + 2'h1;
					else if (!RAM_STALL)
					begin
						RAM_WE <= 1'b0;
						addr_reg <= addr_reg + 17'h1;
						state_reg <= ({15'h0, addr_reg + 17'h1} == len_reg) ?
							fbl_pkg::ST_CLOSE : fbl_pkg::ST_COPY;
					end
				fbl_pkg::ST_CLOSE:
					if (link_done)
						state_reg <= fbl_pkg::ST_REG_OFF;
				fbl_pkg::ST_REG_OFF:
				begin
					FLASH_REG_EN <= 1'b0;
					state_reg <= image_ok_reg ?
						fbl_pkg::ST_DONE : fbl_pkg::ST_NOIMG;
				end
				fbl_pkg::ST_DONE, fbl_pkg::ST_NOIMG:
					state_reg <= state_reg;
				default:
					state_reg <= fbl_pkg::ST_CHECK;
			endcase
		end
	end

	// Pads: strap pulls are set from reset, before any sample is taken
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			PAD_CFG <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
		else
		begin
			PAD_CFG.strap_hi_pullup <= 1'b1;
			PAD_CFG.strap_lo_pulldown <= 1'b1;
			if (state_reg == fbl_pkg::ST_NOIMG)
			begin
				PAD_CFG.uart_alt <= (SEC_SRC == fbl_pkg::SRC_UART);
				PAD_CFG.uart_rx_rts_pullup <= (SEC_SRC == fbl_pkg::SRC_UART);
				PAD_CFG.rts_gpio_pullup <= (SEC_SRC == fbl_pkg::SRC_SPI) ||
					(SEC_SRC == fbl_pkg::SRC_I2C);
				PAD_CFG.spi_alt <= (SEC_SRC == fbl_pkg::SRC_SPI) ||
					(SEC_SRC == fbl_pkg::SRC_I2C);
				PAD_CFG.ss_pullup <= (SEC_SRC == fbl_pkg::SRC_SPI) ||
					(SEC_SRC == fbl_pkg::SRC_I2C);
				PAD_CFG.i2c_alt <= (SEC_SRC == fbl_pkg::SRC_I2C);
			end
		end
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			RAM_ADDR <= fbl_pkg::RAM_BASE;
			RAM_BANK_SEL <= 4'h1;
			ROM_RDATA <= 32'h0;
			BOOT_DONE <= 1'b0;
			BOOT_PC <= fbl_pkg::RAM_BASE;
			NO_IMAGE <= 1'b0;
			ERASE_DONE <= 1'b0;
		end
		else
		begin
			RAM_ADDR <= fbl_pkg::RAM_BASE + {15'h0, addr_reg};
			RAM_BANK_SEL <= bank_of(addr_reg);
			ROM_RDATA <= (ROM_ADDR == fbl_pkg::VERSION_ADDR) ?
				LOADER_VERSION : 32'h0;
			BOOT_DONE <= (state_reg == fbl_pkg::ST_DONE);
			BOOT_PC <= fbl_pkg::RAM_BASE;
			NO_IMAGE <= (state_reg == fbl_pkg::ST_NOIMG);
			ERASE_DONE <= (state_reg == fbl_pkg::ST_ERASE_HOLD);
		end
	end

	// Bank zero holds the wake vectors, so it is never switched off
	generate
		for (genvar b = 0; b < 4; b++)
		begin : g_bank
			always_ff @(posedge CLK or negedge ARST_N)
			begin
				if (!ARST_N)
				begin
					RAM_BANK_PWR[b] <= 1'b1;
					RAM_RETAIN[b] <= 1'b0;
				end
				else
				begin
					RAM_BANK_PWR[b] <= (b == 0) ? 1'b1 :
						!(SLEEP && SLEEP_BANK_OFF[(b == 0) ? 0 : b - 1]);
					RAM_RETAIN[b] <= SLEEP && ((b == 0) ||
						!SLEEP_BANK_OFF[(b == 0) ? 0 : b - 1]);
				end
			end
		end
	endgenerate

	AST_DEBUG_SECURE: assert property (@(posedge CLK) disable iff (!ARST_N)
		$rose(DEBUG_EN) |-> hdr_reg != fbl_pkg::WORD_SECU)
		else $error("Debug enabled on a secure image");
	AST_DONE_REG_OFF: assert property (@(posedge CLK) disable iff (!ARST_N)
		$rose(BOOT_DONE) |-> !FLASH_REG_EN && !RAM_WE)
		else $error("Boot done while flash powered");
	AST_WAKE_SKIP: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state_reg == fbl_pkg::ST_CHECK && WAKE) |-> ##2 BOOT_DONE &&
		!FLASH_REG_EN)
		else $error("Wake did not jump to RAM");
	AST_ERASE_ENTRY: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state_reg == fbl_pkg::ST_STRAP && !hi_s2_reg && lo_s2_reg &&
		wait_reg == 32'(fbl_pkg::STRAP_SETTLE_CYC - 1))
		|=> state_reg == fbl_pkg::ST_ERASE_WREN)
		else $error("Erase straps ignored");
	AST_TOP_SECTOR: assert property (@(posedge CLK) disable iff (!ARST_N)
		state_reg == fbl_pkg::ST_ERASE_CMD |->
		{1'b0, sector_reg} < fbl_pkg::FLASH_SECTORS - 6'h1)
		else $error("Top sector erased");
	AST_RAM_TWO: assert property (@(posedge CLK) disable iff (!ARST_N)
		$rose(RAM_WE) |-> RAM_WE ##1 RAM_WE)
		else $error("RAM write shorter than two cycles");
	AST_RAM_STALL: assert property (@(posedge CLK) disable iff (!ARST_N)
		(RAM_WE && RAM_STALL) |=> RAM_WE)
		else $error("Write dropped under stall");
	AST_CLAMP: assert property (@(posedge CLK) disable iff (!ARST_N)
		state_reg == fbl_pkg::ST_COPY |-> len_reg <= fbl_pkg::RAM_BYTES)
		else $error("Count not clamped");
	AST_BANK0: assert property (@(posedge CLK) disable iff (!ARST_N)
		##1 RAM_BANK_PWR[0])
		else $error("Bank zero powered down");
	AST_EXIT_PADS: assert property (@(posedge CLK) disable iff (!ARST_N)
		(BOOT_DONE || NO_IMAGE) |-> PAD_CFG.strap_hi_pullup &&
		PAD_CFG.strap_lo_pulldown)
		else $error("Strap pads not left pulled");

	COV_ERASE: cover property (@(posedge CLK) disable iff (!ARST_N)
		$rose(ERASE_DONE));
	COV_SECURE: cover property (@(posedge CLK) disable iff (!ARST_N)
		$rose(BOOT_DONE) && !DEBUG_EN);
	COV_NOIMG: cover property (@(posedge CLK) disable iff (!ARST_N)
		$rose(NO_IMAGE) && DEBUG_EN);
	COV_WAKE: cover property (@(posedge CLK) disable iff (!ARST_N)
		state_reg == fbl_pkg::ST_CHECK && WAKE);

endmodule : fbl_loader

`default_nettype wire

// file: hw/fbl_pkg.sv
/*
 * Constants, timing figures and carrier types for the flash boot image
 * loader. Assumes a 100 MHz system clock and a bit-serial flash store
 * reached through a dedicated serial port.
 */
`default_nettype none

package fbl_pkg;

	localparam int CLK_MHZ = 100;
	localparam int STRAP_SETTLE_NS = 100;
	localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int SECTOR_ERASE_MS = 75;
	localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_MS * CLK_MHZ * 1000;
	localparam int RAM_ACCESS_CYC = 2;

	localparam logic [31:0] RAM_BASE = 32'h0040_0000;
	localparam logic [16:0] BANK1_OFS = 17'h0_2000;
	localparam logic [16:0] BANK2_OFS = 17'h0_8000;
	localparam logic [16:0] BANK3_OFS = 17'h1_0000;
	localparam logic [31:0] RAM_BYTES = 32'h0001_8000;
	localparam logic [31:0] VERSION_ADDR = 32'h0000_0020;

	localparam logic [31:0] WORD_OKOK = 32'h4f4b_4f4b;
	localparam logic [31:0] WORD_SECU = 32'h5345_4355;

	localparam logic [5:0] FLASH_SECTORS = 6'h20;
	localparam int SECTOR_SHIFT = 12;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;

	// One serial operation, data left-aligned, sent MSB first
	typedef struct packed {
		logic release_cs;
		logic [5:0] nbits;
		logic [31:0] data;
	} fbl_link_req_t;

	typedef struct packed {
		logic strap_hi_pullup;
		logic strap_lo_pulldown;
		logic uart_alt;
		logic uart_rx_rts_pullup;
		logic rts_gpio_pullup;
		logic spi_alt;
		logic ss_pullup;
		logic i2c_alt;
	} fbl_pad_cfg_t;

	typedef enum logic [1:0] {
		SRC_NONE = 2'h0,
		SRC_UART = 2'h1,
		SRC_SPI = 2'h2,
		SRC_I2C = 2'h3
	} fbl_src_t;

	typedef enum logic [14:0] {
		ST_CHECK = 15'h0001,
		ST_STRAP = 15'h0002,
		ST_ERASE_WREN = 15'h0004,
		ST_ERASE_CMD = 15'h0008,
		ST_ERASE_WAIT = 15'h0010,
		ST_ERASE_HOLD = 15'h0020,
		ST_OPEN = 15'h0040,
		ST_HDR = 15'h0080,
		ST_COPY = 15'h0100,
		ST_WRITE = 15'h0200,
		ST_CLOSE = 15'h0400,
		ST_REG_OFF = 15'h0800,
		ST_DONE = 15'h1000,
		ST_NOIMG = 15'h2000,
		ST_IDLE = 15'h4000
	} fbl_state_t;

endpackage : fbl_pkg

`default_nettype wire

// file: tb/fbl_flash_model.sv
/*
 * Behavioural serial flash for the loader bench: read, write enable and
 * sector erase, 128 Kbyte array. Assumes it is clocked by the link clock.
 */
`timescale 1ns/1ps
`default_nettype none

module fbl_flash_model (
	input wire logic SCK,
	input wire logic CS_N,
	input wire logic MOSI,
	input wire logic EN,
	output logic MISO
);
	logic [7:0] mem [0:131071];
	logic [31:0] cmd;
	logic wel;
	int nbit;
	int k;

	initial
	begin
		MISO = 1'b0;
		wel = 1'b0;
		nbit = 0;
		cmd = 32'h0000_0000;
		for (int i = 0; i < 131072; i++)
			mem[i] = 8'h00;
	end

	always @(negedge CS_N)
	begin
		nbit = 0;
		cmd = 32'h0000_0000;
	end

	// Clock only counts while an operation is on the wire, as a gated clock
	always @(negedge SCK)
	begin
		if (!CS_N && EN)
		begin
			nbit++;
			if (nbit <= 32)
				cmd = {cmd[30:0], MOSI};
			else if (cmd[31:24] == 8'h03)
			begin
				k = nbit - 33;
				MISO = mem[(cmd[16:0] + k / 8) % 131072][7 - k % 8];
			end
		end
	end

	// Released line has no pull, so show the opposite of the last bit
	always @(posedge CS_N)
	begin
		MISO = ~MISO;
		if (nbit == 8 && cmd[7:0] == 8'h06)
			wel = 1'b1;
		if (nbit == 32 && cmd[31:24] == 8'h20 && wel)
		begin
			for (int i = 0; i < 4096; i++)
				mem[{cmd[16:12], 12'h000} + i] = 8'hff;
			wel = 1'b0;
		end
	end
endmodule : fbl_flash_model

`default_nettype wire

// file: tb/fbl_loader_tb_top.sv
/*
 * Self-checking bench for the boot image loader: flash boots, secure
 * boot, invalid image, recovery erase, wake, version and bank power.
 * Assumes the package and the flash model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module fbl_loader_tb_top;
	localparam logic [31:0] VERSION = 32'h00a5_0c31; // Arbitrary value
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic arst_n = 1'b0;
	logic miso, cs_n, mosi, reg_en, wake, strap_hi, strap_lo, ram_we;
	logic ram_stall, sleep, debug_en, boot_done, no_image, erase_done;
	fbl_pkg::fbl_src_t sec_src;
	fbl_pkg::fbl_pad_cfg_t pad_cfg;
	logic [31:0] ram_addr, rom_addr, rom_rdata, boot_pc;
	logic [7:0] ram_wdata;
	logic [3:0] bank_sel, bank_pwr, retain;
	logic [2:0] bank_off;
	int seed = 32'h13669c4e;
	int failures = 0;
	int tests_run = 0;
	int exp_addr[$];
	int exp_data[$];
	int cyc = 0;
	int fell_cyc = 0;
	int we_len = 0;
	logic exp_dbg = 1'b0;
	logic reg_prev = 1'b0;
	logic done_prev = 1'b0;
	logic reg_seen = 1'b0;
	logic [7:0] pads [4] = '{8'hc0, 8'hf0, 8'hce, 8'hcf};

	always #5 clk = ~clk;
	always #7.5 link_clk = ~link_clk;

	fbl_loader #(.ERASE_CYCLES(20), .LOADER_VERSION(VERSION)) fbl_loader_i (
		.CLK(clk), .ARST_N(arst_n), .LINK_CLK(link_clk), .FLASH_MISO(miso),
		.FLASH_CS_N(cs_n), .FLASH_MOSI(mosi), .FLASH_REG_EN(reg_en),
		.WAKE(wake), .STRAP_HI(strap_hi), .STRAP_LO(strap_lo),
		.SEC_SRC(sec_src), .PAD_CFG(pad_cfg), .RAM_ADDR(ram_addr),
		.RAM_WDATA(ram_wdata), .RAM_WE(ram_we), .RAM_BANK_SEL(bank_sel),
		.RAM_STALL(ram_stall), .SLEEP(sleep), .SLEEP_BANK_OFF(bank_off),
		.RAM_BANK_PWR(bank_pwr), .RAM_RETAIN(retain), .ROM_ADDR(rom_addr),
		.ROM_RDATA(rom_rdata), .DEBUG_EN(debug_en), .BOOT_DONE(boot_done),
		.BOOT_PC(boot_pc), .NO_IMAGE(no_image), .ERASE_DONE(erase_done));

	fbl_flash_model fbl_flash_model_i (
		.SCK(link_clk), .CS_N(cs_n), .MOSI(mosi),
		.EN(fbl_loader_i.l_busy_reg), .MISO(miso));

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	// Straps and wake must be steady from release, so set them in reset
	task automatic do_reset(input logic wk, input logic hi, input logic lo);
		@(posedge clk);
		#1;
		arst_n = 1'b0;
		wake = wk;
		strap_hi = hi;
		strap_lo = lo;
		reg_seen = 1'b0;
		repeat (4) @(posedge clk);
		check("pads in reset", 8'hc0, pad_cfg);
		check("debug in reset", 1'b0, debug_en);
		check("select in reset", 1'b1, cs_n);
		#1;
		arst_n = 1'b1;
	endtask : do_reset

	task automatic wait_end(input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			if (boot_done === 1'b1 || no_image === 1'b1 || erase_done === 1'b1)
				break;
		end
		repeat (2) @(posedge clk);
		#1;
	endtask : wait_end

	task automatic boot_image(input logic [31:0] word, input int len,
		input logic dbg);
		logic [31:0] r;
		for (int i = 0; i < 4; i++)
			fbl_flash_model_i.mem[i] = word[31 - 8 * i -: 8];
		for (int i = 0; i < 4; i++)
			fbl_flash_model_i.mem[4 + i] = len[8 * i +: 8];
		exp_dbg = dbg;
		for (int i = 0; i < len; i++)
		begin
			r = $random(seed);
			fbl_flash_model_i.mem[8 + i] = r[7:0];
			exp_addr.push_back(32'h0040_0000 + i);
			exp_data.push_back(r[7:0]);
		end
		do_reset(1'b0, 1'b1, 1'b0);
		wait_end(20000);
		check("boot done", 1'b1, boot_done);
		check("debug enable", dbg, debug_en);
		check("exit pads", 8'hc0, pad_cfg);
		check("boot address", 32'h0040_0000, boot_pc);
		check("regulator", 1'b0, reg_en);
		$display("image %h of %0d bytes done", word, len);
	endtask : boot_image

	// Expected writes queued by boot_image, compared at the start of every RAM write
	always @(negedge clk)
	begin
		cyc++;
		if (reg_prev && !reg_en)
			fell_cyc = cyc;
		if (reg_en)
			reg_seen = 1'b1;
		if (!done_prev && boot_done === 1'b1)
		begin
			check("done after regulator", 1'b1, wake || cyc - fell_cyc == 1);
			check("writes left at done", 0, exp_addr.size());
		end
		if (ram_we === 1'b1 && we_len == 0)
		begin
			if (exp_addr.size() == 0)
				check("unexpected write", 32'h0000_0000, ram_addr);
			else
			begin
				check("write address", exp_addr.pop_front(), ram_addr);
				check("write data", exp_data.pop_front(), ram_wdata);
				check("bank select", 4'h1, bank_sel);
				check("debug at write", exp_dbg, debug_en);
			end
		end
		if (ram_we === 1'b1)
			we_len++;
		else if (we_len > 0)
		begin
			check("write strobe length", 1'b1, we_len >= 2);
			we_len = 0;
		end
		reg_prev = reg_en;
		done_prev = boot_done;
	end

	always @(posedge clk)
	begin
		#1;
		ram_stall = ($random(seed) & 3) == 0;
	end

	initial
	begin
		#1_000_000;
		failures++;
		$display("watchdog expired");
		tally_and_finish();
	end

	initial
	begin
		logic [31:0] r;
		logic [3:0] pwr;
		{wake, strap_hi, strap_lo, sleep, ram_stall} = 5'b01000;
		sec_src = fbl_pkg::SRC_NONE;
		bank_off = 3'h0;
		rom_addr = 32'h0000_0000;
		r = $random(seed);
		boot_image(fbl_pkg::WORD_OKOK, 1 + r[3:0], 1'b1);
		boot_image(fbl_pkg::WORD_OKOK, 0, 1'b1);
		boot_image(fbl_pkg::WORD_SECU, 5, 1'b0);
		boot_image(fbl_pkg::WORD_SECU, 3, 1'b0);
		for (int s = 0; s < 4; s++)
		begin
			r = $random(seed);
			for (int i = 0; i < 4; i++)
				fbl_flash_model_i.mem[i] = 8'({8'h00, r[23:0]} >> (24 - 8 * i));
			sec_src = fbl_pkg::fbl_src_t'(s[1:0]);
			do_reset(1'b0, 1'b1, 1'b0);
			wait_end(2000);
			check("no image", 1'b1, no_image);
			check("debug on invalid", 1'b1, debug_en);
			check("no done", 1'b0, boot_done);
			check("source pads", pads[s], pad_cfg);
			$display("invalid image with source %0d done", s);
		end
		sec_src = fbl_pkg::SRC_NONE;
		for (int s = 0; s < 31; s++)
			fbl_flash_model_i.mem[s * 4096 + 5] = 8'h11;
		fbl_flash_model_i.mem[31 * 4096 + 5] = 8'h5a;
		do_reset(1'b0, 1'b0, 1'b1);
		wait_end(30000);
		check("erase done", 1'b1, erase_done);
		check("debug in erase", 1'b0, debug_en);
		for (int s = 0; s < 31; s++)
			check("erased byte", 8'hff, fbl_flash_model_i.mem[s * 4096 + 5]);
		check("kept sector", 8'h5a, fbl_flash_model_i.mem[31 * 4096 + 5]);
		do_reset(1'b0, 1'b1, 1'b0);
		wait_end(2000);
		check("no image after erase", 1'b1, no_image);
		check("debug after erase", 1'b1, debug_en);
		$display("recovery erase done");
		do_reset(1'b1, 1'b1, 1'b0);
		wait_end(50);
		check("wake done", 1'b1, boot_done);
		check("wake regulator", 1'b0, reg_seen);
		$display("wake entry done");
		for (int i = 0; i < 6; i++)
		begin
			r = $random(seed);
			rom_addr = (i < 3) ? 32'h0000_0020 : {r[31:6], 6'h24};
			@(posedge clk);
			#1;
			check("version read", (i < 3) ? VERSION : 32'h0, rom_rdata);
		end
		$display("version read done");
		for (int i = 0; i < 16; i++)
		begin
			{sleep, bank_off} = i[3:0];
			pwr = {~({3{sleep}} & bank_off), 1'b1};
			@(posedge clk);
			#1;
			check("bank power", pwr, bank_pwr);
			check("retention", sleep ? pwr : 4'h0, retain);
		end
		sleep = 1'b0;
		$display("bank power done");
		tally_and_finish();
	end
endmodule : fbl_loader_tb_top

`default_nettype wire
